// [rtl/dps_consts.svh]
// offsets, field positions, reset values and timing counts of the drive power state block
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
// printed object indices (not multiples of four: byte address = 4 * index)
`define DPS_IDX_CMD 16'h6040
`define DPS_IDX_STATE 16'h6041
`define DPS_IDX_MODE_REQ 16'h6060
`define DPS_IDX_MODE_ACT 16'h6061
`define DPS_IDX_CD_MUL 16'h2057
`define DPS_IDX_CD_DIV 16'h2058
`define DPS_IDX_HOLD 16'h3212
// own registers
`define DPS_IDX_IRQ_STAT 16'h7000
`define DPS_IDX_IRQ_CLR 16'h7001
`define DPS_IDX_IRQ_EN 16'h7002
`define DPS_IDX_CTRL 16'h7003
`define DPS_IDX_HALT_CODE 16'h605D
// command word bit positions
`define DPS_CW_SO 0
`define DPS_CW_EV 1
`define DPS_CW_QS 2
`define DPS_CW_EO 3
`define DPS_CW_FR 7
`define DPS_CW_HALT 8
// state word bit positions
`define DPS_SW_INDEX 15
// reset values
`define DPS_MUL_RST 16'h0001
`define DPS_DIV_RST 16'h0001
`define DPS_HALT_RST 16'h0001
// self test length
`define DPS_SELFTEST_NS 100
`define DPS_CLK_NS 5
`define DPS_SELFTEST_CYC ((`DPS_SELFTEST_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`endif

// [rtl/dps_pkg.sv]
// types of the drive power state block
package dps_pkg;
    typedef enum logic [3:0]
    {
        DPS_NOT_READY = 4'h0,
        DPS_SW_DISABLED = 4'h1,
        DPS_READY = 4'h2,
        DPS_SWITCHED_ON = 4'h3,
        DPS_OP_ENABLED = 4'h4,
        DPS_QUICK_STOP = 4'h5,
        DPS_FAULT_REACT = 4'h6,
        DPS_FAULT = 4'h7
    } dps_state_t;
endpackage

// [rtl/dps_step_scale.sv]
// step pulse scaler for clock-direction mode
`timescale 1ns/1ps
`default_nettype none
module dps_step_scale
#(
    parameter int W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic active,
    input wire logic [W-1:0] mul,
    input wire logic [W-1:0] divr,
    // steps
    input wire logic step_in,
    output logic step_out
);
    typedef struct packed
    {
        logic [W+1:0] acc;
        logic out;
    } dps_ss_t;
    dps_ss_t s_r;
    dps_ss_t s_nxt;
    // accumulate mul per input step, emit one output step per div units
    always_comb
    begin
        logic [W+1:0] d;
        d = {2'b00, ((divr == '0) ? W'(1) : divr)};
        s_nxt = s_r;
        s_nxt.out = 1'b0;
        if (!active)
        begin
            s_nxt.acc = '0;
        end
        else if (s_r.acc >= d)
        begin
            // one output per cycle; limits ratio to clock rate
            s_nxt.acc = s_r.acc - d;
            s_nxt.out = 1'b1;
        end
        else if (step_in)
        begin
            s_nxt.acc = s_r.acc + {2'b00, mul};
        end
    end
    // state register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
    assign step_out = s_r.out;
endmodule
`default_nettype wire

// [rtl/dps_core.sv]
// drive power state machine with register port
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.svh"
module dps_core
    import dps_pkg::*;
#(
    parameter int SELFTEST_CYC = `DPS_SELFTEST_CYC,
    parameter logic [7:0] MODE_CLKDIR = 8'hFF
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [17:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // drive side events
    input wire logic fault_evt,
    input wire logic fault_done,
    input wire logic fatal_evt,
    input wire logic selftest_ok,
    input wire logic enc_index_pin,
    input wire logic step_pin,
    // drive outputs
    output logic power_on,
    output logic hold_torque,
    output logic halt_req,
    output logic [7:0] mode_active,
    output logic step_scaled,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        dps_state_t st;
        logic [15:0] cmd;
        logic fr_prev;
        logic [7:0] mode_req;
        logic [7:0] mode_act;
        logic [15:0] mul;
        logic [15:0] divr;
        logic hold;
        logic [15:0] halt_code;
        logic idx_seen;
        logic enc_comm;
        logic [15:0] st_cnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic [15:0] rdata;
        logic [1:0] idx_sync;
        logic [1:0] step_sync;
        logic idx_prev;
        logic step_prev;
    } dps_core_t;
    dps_core_t s_r;
    dps_core_t s_nxt;
    logic step_scaled_w;
    // decode helpers
    function automatic logic is_addr(input logic [17:0] a, input logic [15:0] idx);
        is_addr = (a == {idx, 2'b00});
    endfunction
    function automatic logic [15:0] state_bits(input dps_state_t st);
        logic [15:0] v;
        v = 16'h0000;
        unique case (st)
            DPS_NOT_READY: v = 16'h0000;
            DPS_SW_DISABLED: v = 16'h0040;
            DPS_READY: v = 16'h0021;
            DPS_SWITCHED_ON: v = 16'h0023;
            DPS_OP_ENABLED: v = 16'h0027;
            DPS_QUICK_STOP: v = 16'h0007;
            DPS_FAULT_REACT: v = 16'h000F;
            DPS_FAULT: v = 16'h0008;
        endcase
        state_bits = v;
    endfunction
    // command decode, don't-care bits left out of each compare
    logic c_shutdown, c_switch_on, c_dis_volt, c_qstop, c_enable;
    logic [15:0] cw;
    always_comb
    begin
        cw = s_r.cmd;
        c_shutdown = !cw[7] && cw[2:0] == 3'b110;
        c_switch_on = !cw[7] && !cw[3] && cw[2:0] == 3'b111;
        c_enable = !cw[7] && cw[3] && cw[2:0] == 3'b111;
        c_dis_volt = !cw[7] && !cw[1];
        c_qstop = !cw[7] && !cw[2] && cw[1];
    end
    logic stat_wr_mode;
    logic fr_rise;
    logic idx_rise;
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [2:0] ev;
        s_nxt = s_r;
        ev = 3'b000;
        s_nxt.idx_sync = {s_r.idx_sync[0], enc_index_pin};
        s_nxt.step_sync = {s_r.step_sync[0], step_pin};
        s_nxt.idx_prev = s_r.idx_sync[1];
        // edge detect on the second stage only, the first may still be metastable
        s_nxt.step_prev = s_r.step_sync[1];
        idx_rise = s_r.idx_sync[1] && !s_r.idx_prev;
        fr_rise = s_r.cmd[`DPS_CW_FR] && !s_r.fr_prev;
        s_nxt.fr_prev = s_r.cmd[`DPS_CW_FR];
        stat_wr_mode = (s_r.st == DPS_SW_DISABLED) || (s_r.st == DPS_READY)
            || (s_r.st == DPS_SWITCHED_ON);
        if (idx_rise && s_r.enc_comm)
        begin
            s_nxt.idx_seen = 1'b1;
        end
        // power state transitions; anything else holds state
        if (fatal_evt)
        begin
            s_nxt.st = DPS_NOT_READY;
        end
        else
        begin
            unique case (s_r.st)
                DPS_NOT_READY:
                begin
                    // after a fatal error the counter is parked at max
                    if (s_r.st_cnt == 16'(SELFTEST_CYC) && selftest_ok)
                    begin
                        s_nxt.st = DPS_SW_DISABLED;
                    end
                    else if (s_r.st_cnt < 16'(SELFTEST_CYC))
                    begin
                        s_nxt.st_cnt = s_r.st_cnt + 16'h0001;
                    end
                end
                DPS_SW_DISABLED:
                    if (fault_evt) s_nxt.st = DPS_FAULT_REACT;
                    else if (c_shutdown) s_nxt.st = DPS_READY;
                DPS_READY:
                    if (fault_evt) s_nxt.st = DPS_FAULT_REACT;
                    else if (c_dis_volt || c_qstop) s_nxt.st = DPS_SW_DISABLED;
                    else if (c_switch_on) s_nxt.st = DPS_SWITCHED_ON;
                DPS_SWITCHED_ON:
                    if (fault_evt) s_nxt.st = DPS_FAULT_REACT;
                    else if (c_dis_volt || c_qstop) s_nxt.st = DPS_SW_DISABLED;
                    else if (c_shutdown) s_nxt.st = DPS_READY;
                    else if (c_enable)
                    begin
                        s_nxt.st = DPS_OP_ENABLED;
                        s_nxt.mode_act = s_r.mode_req;
                    end
                DPS_OP_ENABLED:
                    if (fault_evt) s_nxt.st = DPS_FAULT_REACT;
                    else if (c_dis_volt) s_nxt.st = DPS_SW_DISABLED;
                    else if (c_qstop) s_nxt.st = DPS_QUICK_STOP;
                    else if (c_shutdown) s_nxt.st = DPS_READY;
                    else if (c_switch_on) s_nxt.st = DPS_SWITCHED_ON;
                DPS_QUICK_STOP:
                    if (fault_evt) s_nxt.st = DPS_FAULT_REACT;
                    else if (c_dis_volt) s_nxt.st = DPS_SW_DISABLED;
                DPS_FAULT_REACT:
                    if (fault_done) s_nxt.st = DPS_FAULT;
                DPS_FAULT:
                    if (fr_rise && !fault_evt) s_nxt.st = DPS_SW_DISABLED;
                default:
                    s_nxt.st = DPS_NOT_READY;
            endcase
        end
        if (fatal_evt)
        begin
            s_nxt.st_cnt = 16'hFFFF;
        end
        // interrupt events: state change, fault, index seen
        ev[0] = (s_nxt.st != s_r.st);
        ev[1] = (s_nxt.st == DPS_FAULT_REACT) && (s_r.st != DPS_FAULT_REACT);
        ev[2] = s_nxt.idx_seen && !s_r.idx_seen;
        // register writes
        if (reg_wr)
        begin
            if (is_addr(reg_addr, `DPS_IDX_CMD)) s_nxt.cmd = reg_wdata;
            if (is_addr(reg_addr, `DPS_IDX_MODE_REQ) && stat_wr_mode) s_nxt.mode_req = reg_wdata[7:0];
            if (is_addr(reg_addr, `DPS_IDX_CD_MUL)) s_nxt.mul = reg_wdata;
            if (is_addr(reg_addr, `DPS_IDX_CD_DIV)) s_nxt.divr = reg_wdata;
            if (is_addr(reg_addr, `DPS_IDX_HOLD)) s_nxt.hold = (reg_wdata == 16'h0001);
            if (is_addr(reg_addr, `DPS_IDX_HALT_CODE)) s_nxt.halt_code = reg_wdata;
            if (is_addr(reg_addr, `DPS_IDX_IRQ_EN)) s_nxt.irq_en = reg_wdata[2:0];
            if (is_addr(reg_addr, `DPS_IDX_CTRL)) s_nxt.enc_comm = reg_wdata[0];
            if (is_addr(reg_addr, `DPS_IDX_IRQ_CLR)) s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata[2:0];
        end
        // set wins over clear
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        // read data, valid only in the cycle after the strobe
        s_nxt.rdata = 16'h0000;
        if (reg_rd)
        begin
            if (is_addr(reg_addr, `DPS_IDX_CMD)) s_nxt.rdata = s_r.cmd;
            else if (is_addr(reg_addr, `DPS_IDX_STATE))
                s_nxt.rdata = state_bits(s_r.st) | {s_r.idx_seen, 15'h0000};
            else if (is_addr(reg_addr, `DPS_IDX_MODE_REQ)) s_nxt.rdata = {8'h00, s_r.mode_req};
            else if (is_addr(reg_addr, `DPS_IDX_MODE_ACT)) s_nxt.rdata = {8'h00, s_r.mode_act};
            else if (is_addr(reg_addr, `DPS_IDX_CD_MUL)) s_nxt.rdata = s_r.mul;
            else if (is_addr(reg_addr, `DPS_IDX_CD_DIV)) s_nxt.rdata = s_r.divr;
            else if (is_addr(reg_addr, `DPS_IDX_HOLD)) s_nxt.rdata = {15'h0000, s_r.hold};
            else if (is_addr(reg_addr, `DPS_IDX_HALT_CODE)) s_nxt.rdata = s_r.halt_code;
            else if (is_addr(reg_addr, `DPS_IDX_IRQ_STAT)) s_nxt.rdata = {13'h0000, s_r.irq_stat};
            else if (is_addr(reg_addr, `DPS_IDX_IRQ_EN)) s_nxt.rdata = {13'h0000, s_r.irq_en};
            else if (is_addr(reg_addr, `DPS_IDX_CTRL)) s_nxt.rdata = {15'h0000, s_r.enc_comm};
        end
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.st <= DPS_NOT_READY;
            s_r.mul <= `DPS_MUL_RST;
            s_r.divr <= `DPS_DIV_RST;
            s_r.halt_code <= `DPS_HALT_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic halt_mode;
    // halt only meaningful in pp, vl, pv, tq, ip modes
    assign halt_mode = (s_r.mode_act == 8'h01) || (s_r.mode_act == 8'h02) || (s_r.mode_act == 8'h03)
        || (s_r.mode_act == 8'h04) || (s_r.mode_act == 8'h07);
    assign reg_rdata = s_r.rdata;
    assign power_on = (s_r.st == DPS_OP_ENABLED) || (s_r.st == DPS_QUICK_STOP);
    assign hold_torque = (s_r.st == DPS_SWITCHED_ON) && s_r.hold;
    assign halt_req = (s_r.st == DPS_OP_ENABLED) && halt_mode && s_r.cmd[`DPS_CW_HALT];
    assign mode_active = s_r.mode_act;
    assign irq = |(s_r.irq_stat & s_r.irq_en);
    assign step_scaled = step_scaled_w;
    // clock-direction scaler
    dps_step_scale #(.W(16)) u_scale
    (
        .core_clk(core_clk),
        .rst(rst),
        .active((s_r.st == DPS_OP_ENABLED) && (s_r.mode_act == MODE_CLKDIR)),
        .mul(s_r.mul),
        .divr(s_r.divr),
        .step_in(s_r.step_sync[1] && !s_r.step_prev),
        .step_out(step_scaled_w)
    );
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fatal;
        @(posedge core_clk) disable iff (rst) fatal_evt |=> s_r.st == DPS_NOT_READY;
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal not locked");
    property p_lock;
        @(posedge core_clk) disable iff (rst) (s_r.st_cnt == 16'hFFFF) |=> s_r.st == DPS_NOT_READY;
    endproperty
    a_lock: assert property (p_lock) else $error("left locked state");
    property p_fr;
        @(posedge core_clk) disable iff (rst)
            (s_r.st == DPS_FAULT) && $stable(s_r.cmd[7]) && !fatal_evt |=> s_r.st == DPS_FAULT;
    endproperty
    a_fr: assert property (p_fr) else $error("fault left without edge");
    property p_mode;
        @(posedge core_clk) disable iff (rst) (s_r.st == DPS_OP_ENABLED) |=> $stable(s_r.mode_req);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed while running");
    property p_act;
        @(posedge core_clk) disable iff (rst) $changed(s_r.mode_act) |-> s_r.st == DPS_OP_ENABLED;
    endproperty
    a_act: assert property (p_act) else $error("mode applied outside enable");
    property p_hold;
        @(posedge core_clk) disable iff (rst) hold_torque |-> s_r.hold && s_r.st == DPS_SWITCHED_ON;
    endproperty
    a_hold: assert property (p_hold) else $error("hold torque wrong");
    property p_en;
        @(posedge core_clk) disable iff (rst)
            (s_r.st == DPS_SWITCHED_ON) && c_enable && !fault_evt && !fatal_evt |=> s_r.st == DPS_OP_ENABLED;
    endproperty
    a_en: assert property (p_en) else $error("enable ignored");
    property p_ign;
        @(posedge core_clk) disable iff (rst)
            (s_r.st == DPS_SW_DISABLED) && (c_switch_on || c_enable) && !fault_evt && !fatal_evt |=> $stable(s_r.st);
    endproperty
    a_ign: assert property (p_ign) else $error("invalid command acted on");
    property p_idx;
        @(posedge core_clk) disable iff (rst) s_r.idx_seen |=> s_r.idx_seen;
    endproperty
    a_idx: assert property (p_idx) else $error("index flag dropped");
    c_op: cover property (@(posedge core_clk) disable iff (rst) s_r.st == DPS_OP_ENABLED);
    c_flt: cover property (@(posedge core_clk) disable iff (rst) s_r.st == DPS_FAULT ##1 s_r.st == DPS_SW_DISABLED);
    c_qs: cover property (@(posedge core_clk) disable iff (rst) s_r.st == DPS_QUICK_STOP);
endmodule
`default_nettype wire

// [tb/dps_fb_master.sv]
// fieldbus master model that writes and reads the drive objects over the register port
`timescale 1ns/1ps
`default_nettype none
module dps_fb_master
(
    // clock
    input wire logic core_clk,
    // register port
    output logic [17:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_addr = 18'h00000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write of an object; commands reach the drive only through these writes
    task automatic write_obj(input logic [15:0] idx, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // stale data is not left on the idle bus
        reg_wdata <= ~d;
    endtask

    // one-cycle read, data stands only in the following cycle
    task automatic read_obj(input logic [15:0] idx, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= {idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // sample mid-cycle, after the registered answer has landed
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [tb/dps_core_tb_top.sv]
// self-checking testbench of the drive power state machine
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.svh"
module dps_core_tb_top;
    import dps_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    typedef struct packed {logic [15:0] cmd; logic [15:0] mask; logic [15:0] exp;} dps_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic fault_evt = 1'b0;
    logic fault_done = 1'b0;
    logic fatal_evt = 1'b0;
    logic selftest_ok = 1'b1;
    logic enc_index_pin = 1'b0;
    logic step_pin = 1'b0;
    logic power_on, hold_torque, halt_req, step_scaled, irq;
    logic [7:0] mode_active;
    logic [15:0] d;
    int errors = 0;
    int n_tests = 0;
    int n_steps = 0;
    // command rows: command word, status mask, expected masked status
    dps_row_t rows [13] = '{
        '{16'h0006, 16'h006F, 16'h0021}, '{16'h0007, 16'h006F, 16'h0023},
        '{16'h000F, 16'h006F, 16'h0027}, '{16'h0007, 16'h006F, 16'h0023},
        '{16'h000F, 16'h006F, 16'h0027}, '{16'h0002, 16'h006F, 16'h0007},
        '{16'h0000, 16'h004F, 16'h0040}, '{16'hF06E, 16'h006F, 16'h0021},
        '{16'h000D, 16'h004F, 16'h0040}, '{16'h0007, 16'h004F, 16'h0040},
        '{16'h000F, 16'h004F, 16'h0040}, '{16'h0006, 16'h006F, 16'h0021},
        '{16'h0002, 16'h004F, 16'h0040}};
    // ----------------------------------------
    // clock, design and master model
    // ----------------------------------------
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    // short self-test keeps the run brief
    dps_core #(.SELFTEST_CYC(2), .MODE_CLKDIR(8'hFF)) u_dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fault_evt(fault_evt), .fault_done(fault_done),
        .fatal_evt(fatal_evt), .selftest_ok(selftest_ok), .enc_index_pin(enc_index_pin),
        .step_pin(step_pin), .power_on(power_on), .hold_torque(hold_torque), .halt_req(halt_req),
        .mode_active(mode_active), .step_scaled(step_scaled), .irq(irq));
    dps_fb_master u_fm (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // each scaled step holds step_scaled high one cycle, back-to-back steps run together, so count every clock edge it is high
    always @(posedge core_clk)
    begin
        if (step_scaled === 1'b1)
            n_steps <= n_steps + 1;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // command lands one edge later, state one more
    task automatic cmd(input logic [15:0] c);
        u_fm.write_obj(`DPS_IDX_CMD, c);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic chk_state(input string what, input logic [15:0] mask, input logic [15:0] exp);
        u_fm.read_obj(`DPS_IDX_STATE, d);
        check(what, exp, d & mask);
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // self-test of 2 cycles plus margin
        repeat (8) @(posedge core_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 4000 cycles
    initial
    begin
        #200000;
        errors++;
        end_of_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        do_reset();
        chk_state("state after self-test", 16'h004F, 16'h0040);
        check("hold default", 16'h0000, {15'h0, hold_torque});
        u_fm.write_obj(`DPS_IDX_IRQ_EN, 16'h0007);
        // encoder commutation only; closed loop is never selected, so no auto setup is due
        u_fm.write_obj(`DPS_IDX_CTRL, 16'h0001);
        // table of commands, invalid and don't-care rows among them
        foreach (rows[i])
        begin
            cmd(rows[i].cmd);
            chk_state("state row", rows[i].mask, rows[i].exp);
        end
        $display("test command table done");
        // mode only applied on entering operation, frozen while running
        u_fm.write_obj(`DPS_IDX_MODE_REQ, 16'h0001);
        check("mode before op", 16'h0000, {8'h00, mode_active});
        cmd(16'h0006);
        cmd(16'h0007);
        check("hold off", 16'h0000, {15'h0, hold_torque});
        u_fm.write_obj(`DPS_IDX_HOLD, 16'h0001);
        repeat (2) @(posedge core_clk);
        check("hold on", 16'h0001, {15'h0, hold_torque});
        cmd(16'h000F);
        check("mode in op", 16'h0001, {8'h00, mode_active});
        check("power in op", 16'h0001, {15'h0, power_on});
        u_fm.read_obj(`DPS_IDX_MODE_ACT, d);
        check("mode object", 16'h0001, d);
        u_fm.write_obj(`DPS_IDX_MODE_REQ, 16'h0003);
        u_fm.read_obj(`DPS_IDX_MODE_REQ, d);
        check("mode write refused", 16'h0001, d);
        cmd(16'h010F);
        check("halt set", 16'h0001, {15'h0, halt_req});
        cmd(16'h000F);
        check("halt clear", 16'h0000, {15'h0, halt_req});
        cmd(16'h0000);
        $display("test mode hold halt done");
        // clock-direction scaling: 8 steps at 1/2, then 4 steps at 2/1
        u_fm.write_obj(`DPS_IDX_MODE_REQ, 16'h00FF);
        cmd(16'h0006);
        cmd(16'h0007);
        cmd(16'h000F);
        for (int k = 0; k < 2; k++)
        begin
            u_fm.write_obj(`DPS_IDX_CD_MUL, k ? 16'h0002 : 16'h0001);
            u_fm.write_obj(`DPS_IDX_CD_DIV, k ? 16'h0001 : 16'h0002);
            @(negedge core_clk);
            n_steps = 0;
            @(posedge core_clk);
            repeat (k ? 4 : 8)
            begin
                step_pin <= 1'b1;
                repeat (6) @(posedge core_clk);
                step_pin <= 1'b0;
                repeat (10) @(posedge core_clk);
            end
            repeat (20) @(posedge core_clk);
            check("scaled steps", 16'h0008 >> (1 - k), n_steps[15:0]);
        end
        cmd(16'h0000);
        $display("test step scaling done");
        // fault path, rising edge of bit 7 only, masked and cleared interrupt
        u_fm.write_obj(`DPS_IDX_IRQ_CLR, 16'h0007);
        fault_evt <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_state("fault reaction", 16'h004F, 16'h000F);
        @(posedge core_clk);
        fault_evt <= 1'b0;
        fault_done <= 1'b1;
        repeat (4) @(posedge core_clk);
        fault_done <= 1'b0;
        chk_state("fault", 16'h004F, 16'h0008);
        check("irq on fault", 16'h0001, {15'h0, irq});
        u_fm.read_obj(`DPS_IDX_IRQ_STAT, d);
        check("irq status", 16'h0002, d & 16'h0002);
        u_fm.write_obj(`DPS_IDX_IRQ_CLR, 16'h0007);
        u_fm.write_obj(`DPS_IDX_IRQ_EN, 16'h0002);
        repeat (2) @(posedge core_clk);
        check("irq cleared", 16'h0000, {15'h0, irq});
        cmd(16'h0080);
        chk_state("fault reset", 16'h004F, 16'h0040);
        check("irq masked", 16'h0000, {15'h0, irq});
        @(posedge core_clk);
        fault_evt <= 1'b1;
        repeat (4) @(posedge core_clk);
        fault_evt <= 1'b0;
        fault_done <= 1'b1;
        repeat (4) @(posedge core_clk);
        fault_done <= 1'b0;
        cmd(16'h0080);
        chk_state("steady bit 7", 16'h004F, 16'h0008);
        cmd(16'h0000);
        cmd(16'h0080);
        chk_state("second edge", 16'h004F, 16'h0040);
        $display("test fault done");
        // encoder index flag and its interrupt
        chk_state("no index yet", 16'h8000, 16'h0000);
        u_fm.write_obj(`DPS_IDX_IRQ_EN, 16'h0004);
        enc_index_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        enc_index_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk_state("index seen", 16'h8000, 16'h8000);
        check("irq index", 16'h0001, {15'h0, irq});
        $display("test index done");
        // unrecoverable error locks the state until reset
        @(posedge core_clk);
        fatal_evt <= 1'b1;
        @(posedge core_clk);
        fatal_evt <= 1'b0;
        repeat (3) @(posedge core_clk);
        cmd(16'h0006);
        cmd(16'h0000);
        cmd(16'h0080);
        chk_state("locked", 16'h004F, 16'h0000);
        check("power off locked", 16'h0000, {15'h0, power_on});
        u_fm.read_obj(16'h1234, d);
        check("unmapped read", 16'h0000, d);
        do_reset();
        chk_state("after second reset", 16'h004F, 16'h0040);
        check("mode after reset", 16'h0000, {8'h00, mode_active});
        $display("test fatal and reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
